// ==== src/icg_consts.svh ====
/*
 * Offsets, field positions, reset values and timing figures for the input
 * gain and AGC control bank.
 * Assumes it is included by bare name from the design file.
 */
`ifndef ICG_CONSTS_SVH
`define ICG_CONSTS_SVH

// Register offsets on the host register port.
`define ICG_OFS_HANDSET 8'h1e
`define ICG_OFS_CP_BUZ 8'h1f

// Handset register field positions.
`define ICG_HND_MUTE_BIT 15
`define ICG_HND_GAIN_MSB 14
`define ICG_HND_GAIN_LSB 8
`define ICG_HND_TGT_MSB 7
`define ICG_HND_TGT_LSB 5
`define ICG_HND_TC_MSB 4
`define ICG_HND_TC_LSB 1
`define ICG_HND_AGC_BIT 0

// Cell-phone and buzzer register field positions.
`define ICG_CP_PD_BIT 15
`define ICG_CP_GAIN_MSB 14
`define ICG_CP_GAIN_LSB 8
`define ICG_CP_FLAG_BIT 7
`define ICG_BZ_PD_BIT 6
`define ICG_BZ_GAIN_MSB 5
`define ICG_BZ_GAIN_LSB 2
`define ICG_BZ_FLAG_BIT 1

// Reset values.
`define ICG_RST_HND_MUTE 1'h1
`define ICG_RST_HND_GAIN 7'h7f
`define ICG_RST_HND_TGT 3'h0
`define ICG_RST_HND_TC 4'h0
`define ICG_RST_HND_AGC 1'h0
`define ICG_RST_CP_PD 1'h1
`define ICG_RST_CP_GAIN 7'h45
`define ICG_RST_BZ_PD 1'h1
`define ICG_RST_BZ_GAIN 4'hf

// Cell-phone gain codes: lowest code and the code where gain caps at 12 dB.
`define ICG_CP_GAIN_MIN 7'h00
`define ICG_CP_GAIN_CAP 7'h5d

// AGC time constants in milliseconds.
`define ICG_ATTACK_MS_0 8
`define ICG_ATTACK_MS_1 11
`define ICG_ATTACK_MS_2 16
`define ICG_ATTACK_MS_3 20
`define ICG_DECAY_MS_0 100
`define ICG_DECAY_MS_1 200
`define ICG_DECAY_MS_2 400
`define ICG_DECAY_MS_3 500

// System clock rate and the derived cycles per millisecond.
`define ICG_CLK_HZ 100000000
`define ICG_CYC_PER_MS (`ICG_CLK_HZ / 1000)

`endif

// ==== src/icg_pkg.sv ====
/*
 * Types shared by the input gain and AGC control bank.
 * Assumes icg_consts.svh is reachable on the include path.
 */
`default_nettype none

package icg_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   // Handset configuration as the analog and AGC logic sees it.
   typedef struct packed {
      logic mute;        // Handset input mute.
      logic [6:0] gain;  // Handset gain code, 0.5 dB steps.
      logic [2:0] target; // AGC target level code.
      logic [3:0] tconst; // AGC time-constant code.
      logic agc_en;      // AGC enable.
   } icg_handset_t;

   // Cell-phone and buzzer programmed settings.
   typedef struct packed {
      logic cp_pd;       // Cell-phone amplifier power-down.
      logic [6:0] cp_gain; // Programmed cell-phone gain code.
      logic bz_pd;       // Buzzer amplifier power-down.
      logic [3:0] bz_gain; // Programmed buzzer gain code.
   } icg_cpbuz_t;

endpackage : icg_pkg

`default_nettype wire

// ==== src/icg_gain_ctrl.sv ====
/*
 * Input gain and AGC control bank: handset, cell-phone and buzzer gain
 * registers with soft-stepping of applied gain and status flags.
 * Assumes a host port decoder on clk_sys drives single-cycle read and write
 * strobes, fsref_tick is a one-cycle pulse per reference sample period, and
 * AGC gain inputs come from logic on the same clock.
 */
// Summary of operation
// - Handset mute bit 15, resets to one
// - Handset gain seven bits, 0.5 dB, reset max
// - AGC handset gain read back as signed
// - Three-bit AGC target level field
// - AGC time constants independent of sample rate
// - Handset AGC enable bit 0, resets zero
// - Cell-phone power-down bit 15, resets one
// - Cell-phone gain seven bits, capped 12 dB
// - Cell-phone gain read-only under AGC
// - Cell-phone bit 7 flags step completion
// - Bit 7 is saturation flag under AGC
// - Buzzer power-down bit 6, resets one
// - Buzzer gain four bits, 3 dB steps
// - Buzzer bit 1 flags step completion
// - Reserved bit 0 reads zero, write zero
// - Cell-phone steps one code per sample
// - Buzzer steps one code per sample
// - Soft-step disable bit applies gain immediately
`include "icg_consts.svh"
`default_nettype none

module icg_gain_ctrl #(
   parameter int unsigned CYC_PER_MS = `ICG_CYC_PER_MS // Clock cycles per millisecond.
) (
   input wire logic clk_sys, // System clock, 100 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic reg_wr_en, // Register write strobe.
   input wire logic reg_rd_en, // Register read strobe.
   input wire logic [7:0] reg_addr, // Register offset.
   input wire logic [15:0] reg_wdata, // Write data.
   output logic [15:0] reg_rdata, // Read data, valid the cycle after the strobe.
   input wire logic fsref_tick, // One pulse per reference sample period.
   input wire logic cp_softstep_disable, // Cell-phone soft-step disable.
   input wire logic buzzer_softstep_disable, // Buzzer soft-step disable.
   input wire logic handset_input_selected, // Handset is the chosen ADC input.
   input wire logic cp_agc_enable, // AGC drives the cell-phone input.
   input wire logic [7:0] agc_handset_gain, // AGC handset gain, signed half-dB.
   input wire logic [6:0] agc_cp_gain, // AGC cell-phone gain code.
   output icg_pkg::icg_handset_t handset_cfg, // Handset settings.
   output logic [25:0] handset_attack_cycles, // AGC attack time in clock cycles.
   output logic [25:0] handset_decay_cycles, // AGC decay time in clock cycles.
   output logic cellphone_amp_powerdown, // Cell-phone amplifier power-down.
   output logic [6:0] cellphone_applied_gain, // Gain code applied to cell-phone PGA.
   output logic buzzer_amp_powerdown, // Buzzer amplifier power-down.
   output logic [3:0] buzzer_applied_gain // Gain code applied to buzzer PGA.
);

   // One time scale for the design and the bench, so mixed compiles agree.
   timeunit 1ns;
   timeprecision 1ps;

   // Address match, shared by the write and read paths.
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction : addr_hit

   icg_pkg::icg_handset_t hnd_reg; // Stored handset fields.
   icg_pkg::icg_handset_t hnd_next; // Next handset fields.
   icg_pkg::icg_cpbuz_t cpb_reg; // Stored cell-phone and buzzer fields.
   icg_pkg::icg_cpbuz_t cpb_next; // Next cell-phone and buzzer fields.
   logic [6:0] cp_applied_reg; // Applied cell-phone gain.
   logic [6:0] cp_applied_next; // Next applied cell-phone gain.
   logic [3:0] bz_applied_reg; // Applied buzzer gain.
   logic [3:0] bz_applied_next; // Next applied buzzer gain.
   logic [15:0] rdata_reg; // Registered read data.
   logic [15:0] rdata_next; // Next read data.
   logic [25:0] attack_reg; // Registered attack cycles.
   logic [25:0] attack_next; // Next attack cycles.
   logic [25:0] decay_reg; // Registered decay cycles.
   logic [25:0] decay_next; // Next decay cycles.
   logic [6:0] cp_target; // Programmed cell-phone code after the cap.
   logic hnd_agc_owns; // AGC drives the handset gain.
   logic cp_flag; // Cell-phone status bit.
   logic bz_flag; // Buzzer status bit.
   logic wr_hnd; // Write to the handset register.
   logic wr_cpb; // Write to the cell-phone and buzzer register.

   assign wr_hnd = reg_wr_en && addr_hit(reg_addr, `ICG_OFS_HANDSET);
   assign wr_cpb = reg_wr_en && addr_hit(reg_addr, `ICG_OFS_CP_BUZ);
   assign hnd_agc_owns = hnd_reg.agc_en && handset_input_selected;

   // codes above the cap
   // Codes past the cap all give 12 dB, so stepping aims at the cap itself.
   assign cp_target = (cpb_reg.cp_gain > `ICG_CP_GAIN_CAP) ? `ICG_CP_GAIN_CAP : cpb_reg.cp_gain;

   // Status bits: completion normally; the cell-phone bit shows saturation while AGC drives its input.
   always_comb begin
      if (cp_agc_enable) begin
         cp_flag = (agc_cp_gain == `ICG_CP_GAIN_MIN) || (agc_cp_gain >= `ICG_CP_GAIN_CAP);
      end else begin
         cp_flag = (cp_applied_reg == cp_target);
      end
      bz_flag = (bz_applied_reg == cpb_reg.bz_gain);
   end

   // Next values of the handset fields.
   always_comb begin
      hnd_next = hnd_reg;
      if (wr_hnd) begin
         // AGC-owned fields
         // While AGC drives the handset, its mute and gain are left alone.
         if (!hnd_agc_owns) begin
            hnd_next.mute = reg_wdata[`ICG_HND_MUTE_BIT];
            hnd_next.gain = reg_wdata[`ICG_HND_GAIN_MSB:`ICG_HND_GAIN_LSB];
         end
         hnd_next.target = reg_wdata[`ICG_HND_TGT_MSB:`ICG_HND_TGT_LSB];
         hnd_next.tconst = reg_wdata[`ICG_HND_TC_MSB:`ICG_HND_TC_LSB];
         hnd_next.agc_en = reg_wdata[`ICG_HND_AGC_BIT];
      end
   end

   // Next values of the cell-phone and buzzer fields.
   always_comb begin
      cpb_next = cpb_reg;
      if (wr_cpb) begin
         cpb_next.cp_pd = reg_wdata[`ICG_CP_PD_BIT];
         if (!cp_agc_enable) begin
            cpb_next.cp_gain = reg_wdata[`ICG_CP_GAIN_MSB:`ICG_CP_GAIN_LSB];
         end
         cpb_next.bz_pd = reg_wdata[`ICG_BZ_PD_BIT];
         cpb_next.bz_gain = reg_wdata[`ICG_BZ_GAIN_MSB:`ICG_BZ_GAIN_LSB];
      end
   end

   // Applied gains: jump, step once per sample period, or follow AGC.
   always_comb begin
      cp_applied_next = cp_applied_reg;
      bz_applied_next = bz_applied_reg;
      if (cp_agc_enable) begin
         cp_applied_next = agc_cp_gain;
      end else if (cp_softstep_disable) begin
         cp_applied_next = cp_target;
      end else if (fsref_tick && (cp_applied_reg != cp_target)) begin
         if (cp_applied_reg < cp_target) begin
            cp_applied_next = cp_applied_reg + 7'h01;
         end else begin
            cp_applied_next = cp_applied_reg - 7'h01;
         end
      end
      if (buzzer_softstep_disable) begin
         bz_applied_next = cpb_reg.bz_gain;
      end else if (fsref_tick && (bz_applied_reg != cpb_reg.bz_gain)) begin
         if (bz_applied_reg < cpb_reg.bz_gain) begin
            bz_applied_next = bz_applied_reg + 4'h1;
         end else begin
            bz_applied_next = bz_applied_reg - 4'h1;
         end
      end
   end

   // clock-based time constants
   // Times count system clocks, so the sample rate has no effect on them.
   always_comb begin
      case (hnd_reg.tconst[1:0])
         2'h0: attack_next = 26'(`ICG_ATTACK_MS_0 * CYC_PER_MS);
         2'h1: attack_next = 26'(`ICG_ATTACK_MS_1 * CYC_PER_MS);
         2'h2: attack_next = 26'(`ICG_ATTACK_MS_2 * CYC_PER_MS);
         default: attack_next = 26'(`ICG_ATTACK_MS_3 * CYC_PER_MS);
      endcase
      case (hnd_reg.tconst[3:2])
         2'h0: decay_next = 26'(`ICG_DECAY_MS_0 * CYC_PER_MS);
         2'h1: decay_next = 26'(`ICG_DECAY_MS_1 * CYC_PER_MS);
         2'h2: decay_next = 26'(`ICG_DECAY_MS_2 * CYC_PER_MS);
         default: decay_next = 26'(`ICG_DECAY_MS_3 * CYC_PER_MS);
      endcase
   end

   // Read data, registered; unmapped offsets read zero.
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_en) begin
         rdata_next = 16'h0000;
         if (addr_hit(reg_addr, `ICG_OFS_HANDSET)) begin
            if (hnd_agc_owns) begin
               rdata_next[15:8] = agc_handset_gain;
            end else begin
               rdata_next[`ICG_HND_MUTE_BIT] = hnd_reg.mute;
               rdata_next[`ICG_HND_GAIN_MSB:`ICG_HND_GAIN_LSB] = hnd_reg.gain;
            end
            rdata_next[`ICG_HND_TGT_MSB:`ICG_HND_TGT_LSB] = hnd_reg.target;
            rdata_next[`ICG_HND_TC_MSB:`ICG_HND_TC_LSB] = hnd_reg.tconst;
            rdata_next[`ICG_HND_AGC_BIT] = hnd_reg.agc_en;
         end else if (addr_hit(reg_addr, `ICG_OFS_CP_BUZ)) begin
            rdata_next[`ICG_CP_PD_BIT] = cpb_reg.cp_pd;
            rdata_next[`ICG_CP_GAIN_MSB:`ICG_CP_GAIN_LSB] = cp_agc_enable ? agc_cp_gain : cpb_reg.cp_gain;
            rdata_next[`ICG_CP_FLAG_BIT] = cp_flag;
            rdata_next[`ICG_BZ_PD_BIT] = cpb_reg.bz_pd;
            rdata_next[`ICG_BZ_GAIN_MSB:`ICG_BZ_GAIN_LSB] = cpb_reg.bz_gain;
            rdata_next[`ICG_BZ_FLAG_BIT] = bz_flag;
            rdata_next[0] = 1'h0;
         end
      end
   end

   // State registers.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hnd_reg.mute <= `ICG_RST_HND_MUTE;
         hnd_reg.gain <= `ICG_RST_HND_GAIN;
         hnd_reg.target <= `ICG_RST_HND_TGT;
         hnd_reg.tconst <= `ICG_RST_HND_TC;
         hnd_reg.agc_en <= `ICG_RST_HND_AGC;
         cpb_reg.cp_pd <= `ICG_RST_CP_PD;
         cpb_reg.cp_gain <= `ICG_RST_CP_GAIN;
         cpb_reg.bz_pd <= `ICG_RST_BZ_PD;
         cpb_reg.bz_gain <= `ICG_RST_BZ_GAIN;
         cp_applied_reg <= `ICG_RST_CP_GAIN;
         bz_applied_reg <= `ICG_RST_BZ_GAIN;
         rdata_reg <= 16'h0000;
         attack_reg <= 26'(`ICG_ATTACK_MS_0 * CYC_PER_MS);
         decay_reg <= 26'(`ICG_DECAY_MS_0 * CYC_PER_MS);
      end else begin
         hnd_reg <= hnd_next;
         cpb_reg <= cpb_next;
         cp_applied_reg <= cp_applied_next;
         bz_applied_reg <= bz_applied_next;
         rdata_reg <= rdata_next;
         attack_reg <= attack_next;
         decay_reg <= decay_next;
      end
   end

   // Outputs straight from flip-flops.
   assign reg_rdata = rdata_reg;
   assign handset_cfg = hnd_reg;
   assign handset_attack_cycles = attack_reg;
   assign handset_decay_cycles = decay_reg;
   assign cellphone_amp_powerdown = cpb_reg.cp_pd;
   assign cellphone_applied_gain = cp_applied_reg;
   assign buzzer_amp_powerdown = cpb_reg.bz_pd;
   assign buzzer_applied_gain = bz_applied_reg;

   // Checks on the step sequences and the register answers.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // A soft step request on the cell-phone path.
   sequence seq_cp_step;
      fsref_tick && !cp_agc_enable && !cp_softstep_disable && (cp_applied_reg != cp_target)
         && !wr_cpb;
   endsequence

   // A soft step request on the buzzer path.
   sequence seq_bz_step;
      fsref_tick && !buzzer_softstep_disable && (bz_applied_reg != cpb_reg.bz_gain) && !wr_cpb;
   endsequence

   AST_CP_STEP: assert property (seq_cp_step |=>
      ((cp_applied_reg == $past(cp_applied_reg) + 7'h01) || (cp_applied_reg == $past(cp_applied_reg) - 7'h01)))
      else $error("Cell-phone gain did not move by one code.");

   AST_CP_HOLD: assert property (!fsref_tick && !cp_agc_enable && !cp_softstep_disable |=>
      $stable(cp_applied_reg))
      else $error("Cell-phone gain moved without a sample tick.");

   AST_BZ_STEP: assert property (seq_bz_step |=>
      ((bz_applied_reg == $past(bz_applied_reg) + 4'h1) || (bz_applied_reg == $past(bz_applied_reg) - 4'h1)))
      else $error("Buzzer gain did not move by one code.");

   AST_CP_JUMP: assert property (!cp_agc_enable && cp_softstep_disable && !wr_cpb ##1
      !cp_agc_enable && cp_softstep_disable |-> cp_applied_reg == cp_target)
      else $error("Cell-phone gain did not apply at once.");

   AST_CP_FLAG: assert property (reg_rd_en && addr_hit(reg_addr, `ICG_OFS_CP_BUZ) && !cp_agc_enable |=>
      reg_rdata[`ICG_CP_FLAG_BIT] == ($past(cp_applied_reg) == $past(cp_target)))
      else $error("Cell-phone completion flag wrong.");

   AST_CP_SAT: assert property (reg_rd_en && addr_hit(reg_addr, `ICG_OFS_CP_BUZ) && cp_agc_enable
      && (agc_cp_gain == 7'h00) |=> reg_rdata[`ICG_CP_FLAG_BIT])
      else $error("Saturation flag missing at lowest gain.");

   AST_BZ_FLAG: assert property (reg_rd_en && addr_hit(reg_addr, `ICG_OFS_CP_BUZ) |=>
      reg_rdata[`ICG_BZ_FLAG_BIT] == ($past(bz_applied_reg) == $past(cpb_reg.bz_gain)))
      else $error("Buzzer completion flag wrong.");

   AST_RSVD_ZERO: assert property (reg_rd_en && addr_hit(reg_addr, `ICG_OFS_CP_BUZ) |=>
      reg_rdata[0] == 1'h0)
      else $error("Reserved bit read nonzero.");

   AST_HND_RDBK: assert property (reg_rd_en && addr_hit(reg_addr, `ICG_OFS_HANDSET) && hnd_agc_owns |=>
      reg_rdata[15:8] == $past(agc_handset_gain))
      else $error("Handset AGC gain not read back.");

   AST_CP_RO: assert property (wr_cpb && cp_agc_enable |=>
      cpb_reg.cp_gain == $past(cpb_reg.cp_gain))
      else $error("Cell-phone gain written under AGC.");

   AST_HND_RO: assert property (wr_hnd && hnd_agc_owns |=>
      (hnd_reg.mute == $past(hnd_reg.mute)) && (hnd_reg.gain == $past(hnd_reg.gain)))
      else $error("Handset gain written under AGC.");

   AST_HND_WR: assert property (wr_hnd && !hnd_agc_owns |=>
      hnd_reg.mute == $past(reg_wdata[`ICG_HND_MUTE_BIT]) ##1 handset_cfg.mute == $past(hnd_reg.mute))
      else $error("Handset mute write not taken.");

   AST_TC_CYC: assert property (wr_hnd && (reg_wdata[`ICG_HND_TC_MSB:`ICG_HND_TC_LSB] == 4'hf) |->
      ##2 (handset_attack_cycles == 26'(`ICG_ATTACK_MS_3 * CYC_PER_MS))
      && (handset_decay_cycles == 26'(`ICG_DECAY_MS_3 * CYC_PER_MS)))
      else $error("Time constant cycle count wrong.");

   // The buzzer gain may only move on a sample tick while stepping is on.
   AST_BZ_HOLD: assert property (!fsref_tick && !buzzer_softstep_disable |=>
      $stable(bz_applied_reg))
      else $error("Buzzer gain moved without a sample tick.");

   // With stepping off the buzzer gain lands on the programmed code.
   AST_BZ_JUMP: assert property (buzzer_softstep_disable && !wr_cpb ##1
      buzzer_softstep_disable |-> bz_applied_reg == cpb_reg.bz_gain)
      else $error("Buzzer gain did not apply at once.");

   // A write moves the cell-phone power-down bit to the pin.
   AST_CP_PD_WR: assert property (wr_cpb |=>
      cellphone_amp_powerdown == $past(reg_wdata[`ICG_CP_PD_BIT]))
      else $error("Cell-phone power-down write not taken.");

   // A write moves the buzzer power-down bit to the pin.
   AST_BZ_PD_WR: assert property (wr_cpb |=>
      buzzer_amp_powerdown == $past(reg_wdata[`ICG_BZ_PD_BIT]))
      else $error("Buzzer power-down write not taken.");

endmodule : icg_gain_ctrl

`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench for the input gain and AGC control bank.
 * Assumes the package and the design file are compiled first; the bench drives every input itself.
 */
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned CPM = 10; // Shortened cycles per millisecond.
   logic clk_sys = 1'b0; // Bench clock, 100 MHz.
   logic rst_n = 1'b0; // Reset, active low.
   logic reg_wr_en = 1'b0; // Write strobe.
   logic reg_rd_en = 1'b0; // Read strobe.
   logic [7:0] reg_addr = 8'h00; // Register offset.
   logic [15:0] reg_wdata = 16'h0000; // Write data.
   logic [15:0] reg_rdata; // Read data.
   logic fsref_tick = 1'b0; // Sample-period pulse.
   logic cp_sd = 1'b0; // Cell-phone soft-step disable.
   logic bz_sd = 1'b0; // Buzzer soft-step disable.
   logic hnd_sel = 1'b0; // Handset chosen as converter input.
   logic cp_agc = 1'b0; // AGC owns the cell-phone gain.
   logic [7:0] agc_hg = 8'h00; // AGC handset gain.
   logic [6:0] agc_cg = 7'h00; // AGC cell-phone gain.
   icg_pkg::icg_handset_t handset_cfg; // Handset settings.
   logic [25:0] atk; // Attack cycles.
   logic [25:0] dcy; // Decay cycles.
   logic cp_pd; // Cell-phone power-down.
   logic [6:0] cp_gain; // Applied cell-phone code.
   logic bz_pd; // Buzzer power-down.
   logic [3:0] bz_gain; // Applied buzzer code.
   int n_mismatch = 0; // Mismatches seen.
   int samples_checked = 0; // Comparisons made.
   int atk_ms[4] = '{8, 11, 16, 20}; // Attack times by code.
   int dcy_ms[4] = '{100, 200, 400, 500}; // Decay times by code.
   logic [15:0] rv; // Last word read.

   icg_gain_ctrl #(.CYC_PER_MS(CPM)) u_icg_gain_ctrl (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fsref_tick(fsref_tick),
      .cp_softstep_disable(cp_sd), .buzzer_softstep_disable(bz_sd), .handset_input_selected(hnd_sel),
      .cp_agc_enable(cp_agc), .agc_handset_gain(agc_hg), .agc_cp_gain(agc_cg), .handset_cfg(handset_cfg),
      .handset_attack_cycles(atk), .handset_decay_cycles(dcy), .cellphone_amp_powerdown(cp_pd),
      .cellphone_applied_gain(cp_gain), .buzzer_amp_powerdown(bz_pd), .buzzer_applied_gain(bz_gain)
   );

   // Free-running clock, 10 ns period.
   always #5 clk_sys = ~clk_sys;

   // Counts one comparison of a register word and reports a difference.
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_word

   // Counts one comparison of an output value and reports a difference.
   task automatic cmp_val(input logic [25:0] got, input logic [25:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_val

   // One write strobe, raised and dropped on falling edges.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr_en = 1'b0;
   endtask : wr

   // One read strobe; the word is taken once the answering edge has passed.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      d = reg_rdata;
   endtask : rd

   // Reads a register and compares it with the expected word.
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      rd(a, rv);
      cmp_word(rv, exp);
   endtask : rd_chk

   // One sample-period pulse.
   task automatic tick();
      @(negedge clk_sys);
      fsref_tick = 1'b1;
      @(negedge clk_sys);
      fsref_tick = 1'b0;
   endtask : tick

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // A hang is cut short here and counted as a mismatch.
   initial begin
      #900000;
      n_mismatch++;
      tally_and_finish();
   end

   // Main sequence of tests.
   initial begin
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      // Reset values of both registers and the decoded times.
      rd_chk(8'h1e, 16'hff00);
      rd_chk(8'h1f, 16'hc5fe);
      cmp_val(atk, 26'(8 * CPM));
      cmp_val(dcy, 26'(100 * CPM));
      cmp_val({25'h0, cp_pd & bz_pd}, 26'h1);
      $display("test reset done");
      // Every target and time-constant code.
      for (int c = 0; c < 16; c++) begin
         wr(8'h1e, {8'h00, 3'(c), 4'(c), 1'b0});
         @(negedge clk_sys);
         cmp_word(16'(handset_cfg), {8'h00, 3'(c), 4'(c), 1'b0});
         cmp_val(atk, 26'(atk_ms[c % 4] * CPM));
         cmp_val(dcy, 26'(dcy_ms[c / 4] * CPM));
      end
      $display("test time constants done");
      // Handset under AGC reads back the applied gain and refuses gain writes.
      wr(8'h1e, 16'h0001);
      hnd_sel = 1'b1;
      agc_hg = 8'he8;
      rd_chk(8'h1e, 16'he801);
      agc_hg = 8'h77;
      wr(8'h1e, 16'h7f01);
      rd_chk(8'h1e, 16'h7701);
      cmp_word(16'(handset_cfg), 16'h0001);
      hnd_sel = 1'b0;
      rd_chk(8'h1e, 16'h0001);
      $display("test handset agc done");
      // Soft-stepping one code per sample period.
      wr(8'h1f, 16'h473c);
      rd_chk(8'h1f, 16'h473e);
      cmp_val(26'(cp_gain), 26'h45);
      cmp_val({25'h0, cp_pd | bz_pd}, 26'h0);
      tick();
      cmp_val(26'(cp_gain), 26'h46);
      tick();
      cmp_val(26'(cp_gain), 26'h47);
      rd_chk(8'h1f, 16'h47be);
      wr(8'h1f, 16'h4730);
      rd_chk(8'h1f, 16'h47b0);
      for (int i = 0; i < 3; i++) begin
         tick();
         cmp_val(26'(bz_gain), 26'(14 - i));
      end
      rd_chk(8'h1f, 16'h47b2);
      $display("test soft step done");
      // Disabled stepping applies the code at once; flag bits ignore writes, reserved bit 0 is written as zero.
      cp_sd = 1'b1;
      bz_sd = 1'b1;
      wr(8'h1f, 16'h0082);
      @(negedge clk_sys);
      cmp_val(26'(cp_gain), 26'h0);
      cmp_val(26'(bz_gain), 26'h0);
      rd_chk(8'h1f, 16'h0082);
      $display("test step disable done");
      // Cell-phone under AGC: read-only gain and saturation flag.
      cp_agc = 1'b1;
      rd_chk(8'h1f, 16'h0082);
      agc_cg = 7'h20;
      wr(8'h1f, 16'h1100);
      rd_chk(8'h1f, 16'h2002);
      cmp_val(26'(cp_gain), 26'h20);
      agc_cg = 7'h5d;
      rd_chk(8'h1f, 16'h5d82);
      cp_agc = 1'b0;
      @(negedge clk_sys);
      rd_chk(8'h1f, 16'h0082);
      $display("test cell agc done");
      // Unmapped offsets read zero and writes there change nothing.
      wr(8'h20, 16'hffff);
      rd_chk(8'h20, 16'h0000);
      rd_chk(8'h1e, 16'h0001);
      rd_chk(8'h1f, 16'h0082);
      $display("test unmapped done");
      tally_and_finish();
   end

endmodule : tb

`default_nettype wire
